/* File: core/light_adc_defines.svh */
// Constants for the light sensor integration and readout block.
// Assumes it is included by bare name from core/ sources only.
`ifndef LIGHT_ADC_DEFINES_SVH
`define LIGHT_ADC_DEFINES_SVH

`define SYS_CLK_HZ 50000000
`define OSC_NOM_HZ 300000
`define OSC_DIV (`SYS_CLK_HZ / `OSC_NOM_HZ)
`define INT_CYCLES 32768
`define MAX_EXT_CYCLES 65536

`define ADDR_UPPER 4'h8
`define REG_RESULT_LO 2'h0
`define REG_RESULT_HI 2'h1
`define REG_COUNT_LO 2'h2
`define REG_COUNT_HI 2'h3

`define CMD_RESET_VAL 8'h00
`define CMD_POWER_DOWN 8'h8C
`define CMD_ADC_CLEAR 8'h0C
`define CMD_TEST_BIT 7
`define CMD_SEL_LSB 2
`define CMD_EXT_FIELD 2'h3
`define SEL_DIODE1 2'h0
`define SEL_DIODE2 2'h1
`define SEL_DIFF 2'h2

`define BYTES_INTERNAL 3'h2
`define BYTES_EXTERNAL 3'h4

`endif

/* File: core/light_adc_pkg.sv */
// Types shared by the light sensor readout block.
// Assumes nothing beyond a SystemVerilog compiler.
package light_adc_pkg;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_WRITE = 7'h08,
        ST_WRITE_ACK = 7'h10,
        ST_READ = 7'h20,
        ST_READ_ACK = 7'h40
    } link_state_type;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_INTERNAL,
        KIND_EXTERNAL,
        KIND_POWER_DOWN,
        KIND_CLEAR,
        KIND_TEST
    } cmd_kind_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } link_pins_type;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] result;
    } readout_type;

endpackage

/* File: core/pin_sync.sv */
// Two-stage synchroniser for pins that come from outside sys_clk.
// Assumes the pin levels are stable for at least two clock periods.
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync needs WIDTH of at least one");
        end
    endgenerate

    // Only the second stage may read the first.
    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule

/* File: core/osc_tick_gen.sv */
// Stand-in for the internal integration oscillator: a divider that
// gives one sys_clk pulse per oscillator cycle. Runs regardless of mode.
`timescale 1ns/1ns
module osc_tick_gen #(
    parameter int DIV = 166
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    output logic tick_o
);
    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;

    logic [CW-1:0] div_q;
    logic [CW-1:0] div_d;
    logic tick_q;
    logic tick_d;

    generate
        if (DIV < 2) begin : g_bad_div
            $error("osc_tick_gen needs DIV of at least two");
        end
    endgenerate

    always_comb begin
        if (div_q == CW'(DIV - 1)) begin
            div_d = '0;
            tick_d = 1'b1;
        end else begin
            div_d = div_q + CW'(1);
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
endmodule

/* File: core/light_adc_readout.sv */
// Integration counter, result latches and two-wire readout of the light
// sensor. Assumes diode counts arrive on sys_clk from the converter and
// that SCL, SDA and the address straps are asynchronous pins.
`timescale 1ns/1ns
`include "light_adc_defines.svh"
module light_adc_readout
    import light_adc_pkg::*;
#(
    parameter int OSC_DIV = `OSC_DIV,
    parameter int INT_CYCLES = `INT_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [2:0] addr_pins_i,
    input wire logic [15:0] diode1_count_i,
    input wire logic [15:0] diode2_count_i,
    output logic period_end_o,
    output logic adc_on_o
);
    generate
        if (INT_CYCLES < 2 || INT_CYCLES >= `MAX_EXT_CYCLES) begin : g_bad
            $error("INT_CYCLES must fit the 16-bit integration counter");
        end
    endgenerate

    function automatic cmd_kind_type classify(input logic [7:0] cmd);
        logic [1:0] sel;
        sel = cmd[`CMD_SEL_LSB +: 2];
        if (cmd == `CMD_POWER_DOWN) begin
            classify = KIND_POWER_DOWN;
        end else if (cmd[`CMD_TEST_BIT]) begin
            classify = KIND_TEST;
        end else if (cmd == `CMD_ADC_CLEAR) begin
            classify = KIND_CLEAR;
        end else if (cmd[1:0] != 2'h0 || cmd[6] || sel == 2'h3) begin
            classify = KIND_NONE;
        end else if (cmd[5:4] == `CMD_EXT_FIELD) begin
            classify = KIND_EXTERNAL;
        end else if (cmd[5:4] == 2'h0) begin
            classify = KIND_INTERNAL;
        end else begin
            classify = KIND_NONE;
        end
    endfunction

    // The converter counts are unsigned; their difference is read as
    // two's complement, so the subtraction simply wraps at 16 bits.
    function automatic logic [15:0] pick_result(input logic [7:0] cmd,
            input logic [15:0] d1, input logic [15:0] d2);
        unique case (cmd[`CMD_SEL_LSB +: 2])
            `SEL_DIODE2: pick_result = d2;
            `SEL_DIFF: pick_result = d1 - d2;
            default: pick_result = d1;
        endcase
    endfunction

    function automatic logic [7:0] byte_of(input readout_type r,
            input logic [2:0] idx);
        unique case (idx[1:0])
            `REG_RESULT_LO: byte_of = r.result[7:0];
            `REG_RESULT_HI: byte_of = r.result[15:8];
            `REG_COUNT_LO: byte_of = r.count[7:0];
            default: byte_of = r.count[15:8];
        endcase
    endfunction

    link_pins_type pins_s;
    logic [2:0] addr_s;
    logic tick;

    pin_sync #(.WIDTH(2)) u_link_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i({scl_i, sda_i}),
        .sync_o(pins_s)
    );

    pin_sync #(.WIDTH(3)) u_addr_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(addr_pins_i),
        .sync_o(addr_s)
    );

    osc_tick_gen #(.DIV(OSC_DIV)) u_osc (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .tick_o(tick)
    );

    // Link engine state.
    link_state_type state_q, state_d;
    link_pins_type prev_q, prev_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d;
    logic read_q, read_d;
    logic phase_q, phase_d;
    logic [2:0] byte_idx_q, byte_idx_d;
    logic [2:0] byte_lim_q, byte_lim_d;
    readout_type snap_q, snap_d;
    logic cmd_wr_q, cmd_wr_d;
    logic sda_oe_q, sda_oe_d;
    logic sda_q, sda_d;

    // Integration state.
    logic [7:0] cmd_q, cmd_d;
    logic [15:0] counter_q, counter_d;
    readout_type latched_q, latched_d;
    logic period_end_q, period_end_d;
    logic adc_on_q, adc_on_d;

    logic scl_rise, scl_fall, start_cond, stop_cond;
    logic [7:0] shift_in;
    logic [7:0] first_byte;
    logic [7:0] next_byte;
    cmd_kind_type cur_kind, new_kind;

    assign scl_rise = pins_s.scl && !prev_q.scl;
    assign scl_fall = !pins_s.scl && prev_q.scl;
    assign start_cond = pins_s.scl && prev_q.scl && prev_q.sda && !pins_s.sda;
    assign stop_cond = pins_s.scl && prev_q.scl && !prev_q.sda && pins_s.sda;
    assign shift_in = {shift_q[6:0], pins_s.sda};
    assign first_byte = byte_of(snap_q, 3'h0);
    assign next_byte = byte_of(snap_q, byte_idx_q + 3'h1);
    assign cur_kind = classify(cmd_q);
    assign new_kind = classify(shift_q);

    always_comb begin
        state_d = state_q;
        prev_d = pins_s;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        read_d = read_q;
        phase_d = phase_q;
        byte_idx_d = byte_idx_q;
        byte_lim_d = byte_lim_q;
        snap_d = snap_q;
        cmd_wr_d = 1'b0;
        sda_oe_d = sda_oe_q;
        sda_d = 1'b0;
        if (start_cond) begin
            state_d = ST_ADDR;
            bit_cnt_d = 3'h0;
            sda_oe_d = 1'b0;
        end else if (stop_cond) begin
            state_d = ST_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    sda_oe_d = 1'b0;
                end
                ST_ADDR: if (scl_rise) begin
                    shift_d = shift_in;
                    bit_cnt_d = bit_cnt_q + 3'h1;
                    if (bit_cnt_q == 3'h7) begin
                        if (shift_in[7:1] == {`ADDR_UPPER, addr_s}) begin
                            state_d = ST_ADDR_ACK;
                            read_d = shift_in[0];
                            phase_d = 1'b0;
                            // Freezing a copy here keeps a read consistent
                            // even if a period ends in mid-transfer.
                            snap_d = latched_q;
                            byte_lim_d = `BYTES_INTERNAL;
                            if (cur_kind == KIND_EXTERNAL) begin
                                byte_lim_d = `BYTES_EXTERNAL;
                            end
                            if (cur_kind == KIND_TEST) begin
                                snap_d = {4{cmd_q}};
                            end
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: if (scl_fall) begin
                    if (!phase_q) begin
                        sda_oe_d = 1'b1;
                        phase_d = 1'b1;
                    end else begin
                        phase_d = 1'b0;
                        bit_cnt_d = 3'h0;
                        if (read_q) begin
                            state_d = ST_READ;
                            byte_idx_d = 3'h0;
                            shift_d = first_byte;
                            sda_oe_d = !first_byte[7];
                        end else begin
                            state_d = ST_WRITE;
                            sda_oe_d = 1'b0;
                        end
                    end
                end
                ST_WRITE: if (scl_rise) begin
                    shift_d = shift_in;
                    bit_cnt_d = bit_cnt_q + 3'h1;
                    if (bit_cnt_q == 3'h7) begin
                        cmd_wr_d = 1'b1;
                        state_d = ST_WRITE_ACK;
                        phase_d = 1'b0;
                    end
                end
                ST_WRITE_ACK: if (scl_fall) begin
                    sda_oe_d = !phase_q;
                    phase_d = !phase_q;
                    bit_cnt_d = 3'h0;
                    if (phase_q) begin
                        state_d = ST_WRITE;
                    end
                end
                ST_READ: if (scl_fall) begin
                    bit_cnt_d = bit_cnt_q + 3'h1;
                    shift_d = {shift_q[6:0], 1'b0};
                    sda_oe_d = !shift_q[6];
                    if (bit_cnt_q == 3'h7) begin
                        sda_oe_d = 1'b0;
                        state_d = ST_READ_ACK;
                        phase_d = 1'b0;
                    end
                end
                ST_READ_ACK: begin
                    if (scl_rise) begin
                        phase_d = !pins_s.sda;
                        if (pins_s.sda) begin
                            state_d = ST_IDLE;
                        end
                    end else if (scl_fall && phase_q) begin
                        // Past the limit the line is left released, so the
                        // master sees a not-acknowledge byte of all ones.
                        if (byte_idx_q + 3'h1 < byte_lim_q) begin
                            byte_idx_d = byte_idx_q + 3'h1;
                            shift_d = next_byte;
                            sda_oe_d = !next_byte[7];
                            bit_cnt_d = 3'h0;
                            state_d = ST_READ;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    sda_oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            prev_q <= '1;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            read_q <= 1'b0;
            phase_q <= 1'b0;
            byte_idx_q <= 3'h0;
            byte_lim_q <= `BYTES_INTERNAL;
            snap_q <= '0;
            cmd_wr_q <= 1'b0;
            sda_oe_q <= 1'b0;
            sda_q <= 1'b0;
        end else begin
            state_q <= state_d;
            prev_q <= prev_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            read_q <= read_d;
            phase_q <= phase_d;
            byte_idx_q <= byte_idx_d;
            byte_lim_q <= byte_lim_d;
            snap_q <= snap_d;
            cmd_wr_q <= cmd_wr_d;
            sda_oe_q <= sda_oe_d;
            sda_q <= sda_d;
        end
    end

    // A new command is seen while shift_q still holds its byte.
    always_comb begin
        cmd_d = cmd_q;
        counter_d = counter_q;
        latched_d = latched_q;
        period_end_d = 1'b0;
        adc_on_d = adc_on_q;
        if (cmd_wr_q && new_kind != KIND_NONE) begin
            cmd_d = shift_q;
            adc_on_d = (new_kind != KIND_POWER_DOWN);
            counter_d = 16'h0000;
            if (new_kind == KIND_EXTERNAL && cur_kind == KIND_EXTERNAL) begin
                // The closing period used the old diode selection.
                latched_d.result = pick_result(cmd_q, diode1_count_i,
                    diode2_count_i);
                latched_d.count = counter_q;
                period_end_d = 1'b1;
            end
        end else if (tick && cur_kind == KIND_INTERNAL) begin
            if (counter_q == 16'(INT_CYCLES - 1)) begin
                latched_d.result = pick_result(cmd_q, diode1_count_i,
                    diode2_count_i);
                latched_d.count = 16'(INT_CYCLES);
                counter_d = 16'h0000;
                period_end_d = 1'b1;
            end else begin
                counter_d = counter_q + 16'h0001;
            end
        end else if (tick && cur_kind == KIND_EXTERNAL) begin
            // Wraps silently; the host must end the period in time.
            counter_d = counter_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cmd_q <= `CMD_RESET_VAL;
            counter_q <= 16'h0000;
            latched_q <= '0;
            period_end_q <= 1'b0;
            adc_on_q <= 1'b1;
        end else begin
            cmd_q <= cmd_d;
            counter_q <= counter_d;
            latched_q <= latched_d;
            period_end_q <= period_end_d;
            adc_on_q <= adc_on_d;
        end
    end

    assign sda_o = sda_q;
    assign sda_oe_o = sda_oe_q;
    assign period_end_o = period_end_q;
    assign adc_on_o = adc_on_q;
endmodule

/* File: dv/light_adc_readout_checker.sv */
// Concurrent checks on the ports of the light sensor readout block.
// Assumes it is bound to light_adc_readout and sees SDA after pull-up.
`timescale 1ns/1ns
module light_adc_readout_checker #(
    parameter int OSC_DIV = 166,
    parameter int INT_CYCLES = 32768
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic period_end_o,
    input wire logic adc_on_o
);
    localparam int GAP = OSC_DIV * INT_CYCLES - 1;
    logic [31:0] gap_q, gap_d;
    logic busy_q, busy_d;
    logic seen_q, seen_d;

    // A gap between pulses only proves the period length when no bus
    // traffic since the last pulse could have changed the mode.
    always_comb begin
        gap_d = period_end_o ? 32'h0 : gap_q + 32'h1;
        busy_d = period_end_o ? 1'b0 : (busy_q | ~scl_i);
        seen_d = seen_q | period_end_o;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            gap_q <= 32'h0;
            busy_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= gap_d;
            busy_q <= busy_d;
            seen_q <= seen_d;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n_i |=> !sda_oe_o && !period_end_o && adc_on_o)
        else $error("outputs not quiet after reset");
    a_sda_open_drain: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    a_pulse_single: assert property (period_end_o |=> !period_end_o)
        else $error("period end pulse longer than one cycle");
    a_pulse_spacing: assert property (
        period_end_o |=> !period_end_o [*8])
        else $error("period end pulses too close");
    a_internal_gap: assert property (
        period_end_o && seen_q && !busy_q |-> gap_q == 32'(GAP))
        else $error("self-timed period length wrong");
    a_oe_moves_low: assert property (
        $changed(sda_oe_o) |-> !$past(scl_i))
        else $error("data drive changed while clock high");
    a_oe_steady_high: assert property (
        $rose(scl_i) |=> $stable(sda_oe_o) [*3])
        else $error("data drive moved during clock high");
    a_stop_releases: assert property (
        scl_i && $past(scl_i) && $rose(sda_i) |-> ##4 !sda_oe_o)
        else $error("data still driven after stop");
    a_start_releases: assert property (
        scl_i && $past(scl_i) && $fell(sda_i) |-> ##4 !sda_oe_o)
        else $error("data still driven after start");

    c_period: cover property (period_end_o);
    c_ack: cover property ($rose(sda_oe_o));
    c_stop: cover property (scl_i && $rose(sda_i));
endmodule

bind light_adc_readout light_adc_readout_checker #(
    .OSC_DIV(OSC_DIV),
    .INT_CYCLES(INT_CYCLES)
) light_adc_readout_checker_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .period_end_o(period_end_o), .adc_on_o(adc_on_o)
);

/* File: dv/i2c_host_model.sv */
// Two-wire bus master standing in for the host controller.
// Assumes the bench resolves SDA with a pull-up and feeds it back.
`timescale 1ns/1ns
module i2c_host_model (
    input wire logic sys_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    // Data moves one cycle after SCL falls so it never races the clock.
    task automatic put_bit(input logic b);
        scl_o = 1'b0;
        wt(1);
        sda_pull_o = !b;
        wt(3);
        scl_o = 1'b1;
        wt(4);
    endtask

    task automatic get_bit(output logic b);
        scl_o = 1'b0;
        wt(1);
        sda_pull_o = 1'b0;
        wt(3);
        scl_o = 1'b1;
        wt(2);
        b = sda_i;
        wt(2);
    endtask

    task automatic start();
        wt(4);
        sda_pull_o = 1'b1;
        wt(4);
    endtask

    task automatic stop();
        scl_o = 1'b0;
        wt(1);
        sda_pull_o = 1'b1;
        wt(3);
        scl_o = 1'b1;
        wt(4);
        sda_pull_o = 1'b0;
        wt(4);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        get_bit(nak);
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            get_bit(b[i]);
        end
        put_bit(last);
    endtask
endmodule

/* File: dv/light_adc_integration_readout_bench.sv */
// Self-checking bench for the light sensor readout block.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/1ns
module light_adc_integration_readout_bench;
    localparam int DIV = 4;
    localparam int NCYC = 16;
    localparam logic [2:0] ADDR = 3'h5;
    logic sys_clk = 1'b0;
    logic rst_n, scl, host_pull, sda_line, sda_out, sda_oe;
    logic period_end, adc_on, nak;
    logic [15:0] d1, d2;
    logic [7:0] d [4];
    logic [15:0] exp_tab [3] = '{16'h1234, 16'h2345, 16'hEEEF};
    int cyc = 0;
    int t1, error_cnt = 0, checks_done = 0;

    always #10 sys_clk = ~sys_clk;
    assign sda_line = !host_pull && !(sda_oe && !sda_out);

    light_adc_readout #(.OSC_DIV(DIV), .INT_CYCLES(NCYC)) light_adc_readout_i (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_out), .sda_oe_o(sda_oe),
        .addr_pins_i(ADDR), .diode1_count_i(d1), .diode2_count_i(d2),
        .period_end_o(period_end), .adc_on_o(adc_on)
    );
    i2c_host_model i2c_host_model_i (
        .sys_clk_i(sys_clk), .sda_i(sda_line), .scl_o(scl),
        .sda_pull_o(host_pull)
    );

    task automatic summarize();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check_val(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic check_count(input string nm, input logic [15:0] lo,
                               input logic [15:0] hi, input logic [15:0] g);
        checks_done++;
        if (!(g >= lo && g <= hi)) begin
            error_cnt++;
            $display("BAD %s exp %h..%h got %h", nm, lo, hi, g);
        end
    endtask

    task automatic write_cmds(input logic [7:0] c[$]);
        logic ack_n;
        i2c_host_model_i.start();
        i2c_host_model_i.send_byte({4'h8, ADDR, 1'b0}, ack_n);
        check_val("wr_ack", 16'h0000, {15'h0, ack_n});
        foreach (c[i]) begin
            i2c_host_model_i.send_byte(c[i], ack_n);
        end
        i2c_host_model_i.stop();
    endtask

    task automatic read_bytes(input logic [6:0] adr, input int n);
        i2c_host_model_i.start();
        i2c_host_model_i.send_byte({adr, 1'b1}, nak);
        for (int i = 0; i < n; i++) begin
            if (!nak) begin
                i2c_host_model_i.recv_byte(i == n - 1, d[i]);
            end
        end
        i2c_host_model_i.stop();
    endtask

    task automatic wait_pulse();
        int n;
        n = 0;
        @(negedge sys_clk);
        while (period_end !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        check_val("pulse", 16'h0001, {15'h0, period_end});
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        rst_n = 1'b0;
        d1 = 16'h1234;
        d2 = 16'h2345;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        check_val("adc_on", 16'h0001, {15'h0, adc_on});
        repeat (4) @(negedge sys_clk);
        // Self-timed modes with diode 1, diode 2 and the difference.
        for (int m = 0; m < 3; m++) begin
            write_cmds('{8'(m * 4)});
            wait_pulse();
            t1 = cyc;
            wait_pulse();
            check_val("int_gap", 16'(DIV * NCYC), 16'(cyc - t1));
            read_bytes({4'h8, ADDR}, 3);
            check_val("int_res", exp_tab[m], {d[1], d[0]});
            check_val("int_tail", 16'h00FF, {8'h0, d[2]});
        end
        read_bytes({4'h8, ADDR ^ 3'h1}, 2);
        check_val("bad_adr", 16'h0001, {15'h0, nak});
        // Two host-timed commands one byte time (72 cycles) apart.
        write_cmds('{8'h30, 8'h34});
        read_bytes({4'h8, ADDR}, 4);
        check_val("ext_res", 16'h1234, {d[1], d[0]});
        check_count("ext_cnt", 16'(72 / DIV - 1), 16'(72 / DIV),
                    {d[3], d[2]});
        write_cmds('{8'h38});
        d1 = 16'h0F00;
        d2 = 16'h0100;
        read_bytes({4'h8, ADDR}, 4);
        check_val("ext_hold", 16'h2345, {d[1], d[0]});
        write_cmds('{8'h30});
        read_bytes({4'h8, ADDR}, 4);
        check_val("ext_diff", 16'h0E00, {d[1], d[0]});
        // Power-down drops the converter; any later command not classified KIND_NONE or KIND_POWER_DOWN wakes it.
        write_cmds('{8'h8C});
        check_val("adc_off", 16'h0000, {15'h0, adc_on});
        write_cmds('{8'h9A});
        check_val("adc_wake", 16'h0001, {15'h0, adc_on});
        read_bytes({4'h8, ADDR}, 3);
        check_val("test_echo", 16'h9A9A, {d[1], d[0]});
        check_val("test_tail", 16'h00FF, {8'h0, d[2]});
        summarize();
    end
endmodule
